// *** hdl/compare_channel_pkg.sv ***
// types shared by the compare channel files
// assumes the register header defines the constants
package compare_channel_pkg;
    typedef enum logic [2:0] {
        MODE_OFF    = 3'h0,
        MODE_SETHI  = 3'h1,
        MODE_SETLO  = 3'h2,
        MODE_TOGGLE = 3'h3,
        MODE_ONCE   = 3'h4,
        MODE_TRAIN  = 3'h5,
        MODE_PWM    = 3'h6,
        MODE_PWMFLT = 3'h7
    } cmp_mode_t;

    typedef struct packed {
        logic      enable;
        logic      stopIdle;
        logic      wide;
        logic      timerSel;
        cmp_mode_t mode;
    } cmp_cfg_t;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;
endpackage : compare_channel_pkg

// *** hdl/compare_channel_regs.svh ***
// register offsets, field positions, reset values for the compare channel
// included by the package user modules; definitions only
`ifndef COMPARE_CHANNEL_REGS_SVH
`define COMPARE_CHANNEL_REGS_SVH
`define CC_CTRL_OFFSET     4'h0
`define CC_PRIMARY_OFFSET  4'h4
`define CC_SECOND_OFFSET   4'h8
`define CC_STATUS_OFFSET   4'hc
`define CC_ON_BIT          15
`define CC_STOP_IN_IDLE_BIT        13
`define CC_WIDE_BIT        5
`define CC_FLT_BIT         4
`define CC_TSEL_BIT        3
`define CC_IE_BIT          0
`define CC_CTRL_RESET      32'h0000_0000
`define CC_VALUE_RESET     32'h0000_0000
`define CC_CTRL_WMASK      32'h0000_a02f
`endif

// *** hdl/compare_matcher.sv ***
// compare_matcher: equality of primary and secondary values with the timer
// assumes timer counts are already on ref_clk
`timescale 1ns/1ps
`include "compare_channel_regs.svh"
module compare_matcher
    import compare_channel_pkg::*;
(
    input  wire logic        wide,
    input  wire logic        timerSel,
    input  wire logic [15:0] secondTimer,
    input  wire logic [15:0] thirdTimer,
    input  wire logic [31:0] primaryValue,
    input  wire logic [31:0] secondaryValue,
    output logic             primaryHit,
    output logic             secondaryHit,
    output logic [31:0]      timerNow
);
    // selected count, second timer is low half in wide mode
    always_comb begin
        if (wide)
            timerNow = {thirdTimer, secondTimer};
        else if (timerSel)
            timerNow = {16'h0000, thirdTimer};
        else
            timerNow = {16'h0000, secondTimer};
    end

    // only the low halves count in narrow mode
    assign primaryHit   = wide ? (primaryValue == timerNow)
                               : (primaryValue[15:0] == timerNow[15:0]);
    assign secondaryHit = wide ? (secondaryValue == timerNow)
                               : (secondaryValue[15:0] == timerNow[15:0]);
endmodule : compare_matcher

// *** hdl/output_compare_channel.sv ***
// output_compare_channel: one compare channel with control, values, pin logic
// assumes timers, idle and fault come from outside; fault is a pin
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "compare_channel_regs.svh"
module output_compare_channel
    import compare_channel_pkg::*;
#(
    parameter int TIMER_W = 16
) (
    input  wire logic               ref_clk,
    input  wire logic               nrst,
    input  wire logic [3:0]         regAddr,
    input  wire logic [31:0]        regWdata,
    input  wire logic               regWr,
    input  wire logic               regRd,
    output logic      [31:0]        regRdata,
    input  wire logic [TIMER_W-1:0] secondTimer,
    input  wire logic [TIMER_W-1:0] thirdTimer,
    input  wire logic               periodRestart,
    input  wire logic               cpuIdle,
    input  wire logic               faultPin,
    output logic                    compareOutputPin,
    output logic                    compareIrq
);
    reg_req_t    req;
    cmp_cfg_t    cfg;
    logic        ctrlIe_q;
    logic [31:0] primary_q;
    logic [31:0] secondary_q;
    logic        pin_q;
    logic        pin_d;
    logic        fault_q;
    logic        pulseDone_q;
    logic        event_q;
    logic        fltSync1_q;
    logic        fltSync2_q;
    logic        primaryHit;
    logic        secondaryHit;
    logic [31:0] timerNow;
    logic        running;
    logic        pwmMode;
    logic [31:0] rdata_q;
    logic [31:0] wideCount;

    // write decode shared by every register that software can load
    function automatic logic wrTo(input reg_req_t r, input logic [3:0] a);
        return r.wr && r.addr == a;
    endfunction : wrTo

    assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

    // both timers side by side, the word a wide compare must match
    assign wideCount = {thirdTimer[15:0], secondTimer[15:0]};

    // fault pin is asynchronous; two flops before use
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fltSync1_q <= 1'b0;
            fltSync2_q <= 1'b0;
        end else begin
            fltSync1_q <= faultPin;
            fltSync2_q <= fltSync1_q;
        end
    end

    // control register; unimplemented bits never stored
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cfg      <= '{enable: 1'b0, stopIdle: 1'b0, wide: 1'b0,
                          timerSel: 1'b0, mode: MODE_OFF};
            ctrlIe_q <= 1'b0;
        end else if (wrTo(req, `CC_CTRL_OFFSET)) begin
            cfg.enable   <= req.wdata[`CC_ON_BIT];
            cfg.stopIdle <= req.wdata[`CC_STOP_IN_IDLE_BIT];
            cfg.wide     <= req.wdata[`CC_WIDE_BIT];
            cfg.timerSel <= req.wdata[`CC_TSEL_BIT];
            cfg.mode     <= cmp_mode_t'(req.wdata[2:0]);
        end else if (wrTo(req, `CC_STATUS_OFFSET)) begin
            ctrlIe_q <= req.wdata[`CC_IE_BIT];
        end
    end

    // compare values; secondary reloads primary in pwm at period
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            primary_q   <= `CC_VALUE_RESET;
            secondary_q <= `CC_VALUE_RESET;
        end else begin
            if (wrTo(req, `CC_PRIMARY_OFFSET))
                primary_q <= req.wdata;
            else if (running && pwmMode && periodRestart)
                primary_q <= secondary_q;
            if (wrTo(req, `CC_SECOND_OFFSET))
                secondary_q <= req.wdata;
        end
    end

    compare_matcher u_matcher (
        .wide           (cfg.wide),
        .timerSel       (cfg.timerSel),
        .secondTimer    (secondTimer[15:0]),
        .thirdTimer     (thirdTimer[15:0]),
        .primaryValue   (primary_q),
        .secondaryValue (secondary_q),
        .primaryHit     (primaryHit),
        .secondaryHit   (secondaryHit),
        .timerNow       (timerNow)
    );

    // idle halts only when stop-in-idle is set; mode 000 is off
    assign running = cfg.enable && !(cfg.stopIdle && cpuIdle)
                     && cfg.mode != MODE_OFF;
    assign pwmMode = cfg.mode == MODE_PWM || cfg.mode == MODE_PWMFLT;

    // next pin level by mode
    always_comb begin
        pin_d = pin_q;
        unique case (cfg.mode)
            MODE_OFF:    pin_d = 1'b0;
            MODE_SETHI:  if (primaryHit) pin_d = 1'b1;
            MODE_SETLO:  if (primaryHit) pin_d = 1'b0;
            MODE_TOGGLE: if (primaryHit) pin_d = ~pin_q;
            MODE_ONCE, MODE_TRAIN: begin
                if (primaryHit && !pulseDone_q)
                    pin_d = 1'b1;
                else if (secondaryHit)
                    pin_d = 1'b0;
            end
            MODE_PWM, MODE_PWMFLT: begin
                if (periodRestart)
                    pin_d = 1'b1;
                else if (primaryHit)
                    pin_d = 1'b0;
                if (cfg.mode == MODE_PWMFLT && (fltSync2_q || fault_q))
                    pin_d = 1'b0;
            end
        endcase
    end

    // pin state; a control write reinitialises it for the new mode
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pin_q <= 1'b0;
        end else if (wrTo(req, `CC_CTRL_OFFSET)) begin
            pin_q <= req.wdata[2:0] == 3'h2;
        end else if (!cfg.enable) begin
            pin_q <= 1'b0;
        end else if (running) begin
            pin_q <= pin_d;
        end
    end

    // single pulse ends after its secondary match until the next control write
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
            pulseDone_q <= 1'b0;
        else if (wrTo(req, `CC_CTRL_OFFSET))
            pulseDone_q <= 1'b0;
        else if (running && cfg.mode == MODE_ONCE && pin_q && secondaryHit)
            pulseDone_q <= 1'b1;
    end

    // fault flag: set by hardware, cleared only by leaving fault mode or disabling the channel
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
            fault_q <= 1'b0;
        else if (running && cfg.mode == MODE_PWMFLT && fltSync2_q)
            fault_q <= 1'b1;
        else if (cfg.mode != MODE_PWMFLT || !cfg.enable)
            fault_q <= 1'b0;
    end

    // one-cycle compare event, gated by the interrupt enable
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
            event_q <= 1'b0;
        else
            event_q <= running && ctrlIe_q && (primaryHit
                       || (secondaryHit && (cfg.mode == MODE_ONCE
                       || cfg.mode == MODE_TRAIN)));
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 32'h0000_0000;
        end else if (req.rd) begin
            unique case (req.addr)
                `CC_CTRL_OFFSET: rdata_q <= {16'h0000, cfg.enable, 1'b0, cfg.stopIdle,
                    7'h00, cfg.wide, fault_q && cfg.mode == MODE_PWMFLT,
                    cfg.timerSel, cfg.mode};
                `CC_PRIMARY_OFFSET: rdata_q <= primary_q;
                `CC_SECOND_OFFSET:  rdata_q <= secondary_q;
                `CC_STATUS_OFFSET:  rdata_q <= {30'h0, pin_q, ctrlIe_q};
                default:            rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign regRdata         = rdata_q;
    assign compareOutputPin = pin_q;
    assign compareIrq       = event_q;

    // unimplemented control bits always read zero
    ctrl_reserved_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        $past(req.rd) && $past(req.addr) == `CC_CTRL_OFFSET
        |-> (regRdata & ~`CC_CTRL_WMASK & ~32'h10) == 32'h0)
        else $error("reserved control bits nonzero");

    // fault flag reads zero outside fault mode
    fault_read_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        $past(req.rd) && $past(req.addr) == `CC_CTRL_OFFSET
        && $past(cfg.mode) != MODE_PWMFLT |-> !regRdata[`CC_FLT_BIT])
        else $error("fault flag visible outside fault mode");

    // disabled channel drives pin low
    off_pin_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !cfg.enable && !$past(req.wr) |-> !compareOutputPin)
        else $error("pin active while disabled");

    // fault in fault mode holds pin low
    fault_pin_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        running && cfg.mode == MODE_PWMFLT && fltSync2_q && !req.wr
        |=> !compareOutputPin)
        else $error("fault did not disable output");

    // toggle mode inverts on a match
    toggle_pin_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        running && cfg.mode == MODE_TOGGLE && primaryHit && !req.wr
        |=> compareOutputPin != $past(compareOutputPin))
        else $error("toggle missed");

    // idle halt freezes pin
    idle_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        cfg.enable && cfg.stopIdle && cpuIdle && !req.wr
        |=> $stable(compareOutputPin))
        else $error("pin moved while halted in idle");

    // set-high mode rises on match
    sethi_pin_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        running && cfg.mode == MODE_SETHI && primaryHit && !req.wr
        |=> compareOutputPin)
        else $error("set-high mode did not rise");

    // pwm period start raises pin without fault
    pwm_period_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        running && cfg.mode == MODE_PWM && periodRestart && !req.wr
        |=> compareOutputPin)
        else $error("pwm period did not raise pin");

    // named steps for the pin checks below, each used by one check
    sequence ctrlWrite_s;
        wrTo(req, `CC_CTRL_OFFSET);
    endsequence

    sequence pulseRise_s;
        running && !req.wr && (cfg.mode == MODE_ONCE || cfg.mode == MODE_TRAIN)
        && primaryHit && !pulseDone_q;
    endsequence

    sequence pulseFall_s;
        running && !req.wr && (cfg.mode == MODE_ONCE || cfg.mode == MODE_TRAIN)
        && secondaryHit && !(primaryHit && !pulseDone_q);
    endsequence

    // a control write sets the starting level: high only for 010
    init_level_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        ctrlWrite_s |=> compareOutputPin == (cfg.mode == MODE_SETLO))
        else $error("pin not reinitialised by control write");

    // set-low mode falls on match
    setlo_pin_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        running && cfg.mode == MODE_SETLO && primaryHit && !req.wr
        |=> !compareOutputPin)
        else $error("set-low mode did not fall");

    // mode 000 keeps the pin low and raises no event
    mode_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        cfg.mode == MODE_OFF |-> !compareOutputPin ##1 !compareIrq)
        else $error("compare active in mode 000");

    // compare events reach the request line only when enabled
    irq_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !ctrlIe_q |=> !compareIrq)
        else $error("request raised while disabled");

    // an enabled primary match always raises the request
    irq_event_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        running && ctrlIe_q && primaryHit |=> compareIrq)
        else $error("primary match raised no request");

    // pulse modes rise on the primary match
    pulse_rise_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        pulseRise_s |=> compareOutputPin)
        else $error("pulse did not rise on primary match");

    // and fall on the secondary match
    pulse_fall_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        pulseFall_s |=> !compareOutputPin)
        else $error("pulse did not fall on secondary match");

    // a finished single pulse does not rise again until the next control write
    once_done_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        running && cfg.mode == MODE_ONCE && pulseDone_q && !compareOutputPin && !req.wr
        |=> !compareOutputPin)
        else $error("single pulse repeated");

    // narrow compare: low halves against the second timer by default
    narrow_hit_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !cfg.wide && !cfg.timerSel && primary_q[15:0] == secondTimer[15:0]
        |-> primaryHit)
        else $error("narrow match on second timer missed");

    // timer select moves the narrow compare to the third timer
    third_hit_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !cfg.wide && cfg.timerSel && primary_q[15:0] == thirdTimer[15:0]
        |-> primaryHit)
        else $error("narrow match on third timer missed");

    // wide compare takes the whole word and nothing less
    wide_hit_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        cfg.wide |-> timerNow == wideCount
        && primaryHit == (primary_q == wideCount))
        else $error("wide compare mismatch");

    // pwm period start copies the secondary value into the primary
    value_reload_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        running && pwmMode && periodRestart && !req.wr
        |=> primary_q == $past(secondary_q))
        else $error("primary not reloaded at period start");

    // latched fault survives every write while fault mode stays on
    fault_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        fault_q && cfg.enable && cfg.mode == MODE_PWMFLT |=> fault_q)
        else $error("fault flag cleared in fault mode");
endmodule : output_compare_channel

// *** verif/compare_load_model.sv ***
// compare_load_model: the load hung on the compare output pin
// assumes the bench asks for an overcurrent trip; shares ref_clk with the channel
`timescale 1ns/1ps
module compare_load_model (
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic       pinLevel,
    input  wire logic       tripReq,
    output logic            faultPin,
    output logic [7:0]      riseCount
);
    logic pinLast_q;

    // fault line follows the trip one flop late, like a slow current sense
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            faultPin  <= 1'b0;
            pinLast_q <= 1'b0;
            riseCount <= 8'h00;
        end else begin
            faultPin  <= tripReq;
            pinLast_q <= pinLevel;
            if (pinLevel && !pinLast_q) riseCount <= riseCount + 8'h01; // counts pulses seen
        end
    end
endmodule : compare_load_model

// *** verif/output_compare_channel_bench.sv ***
// output_compare_channel_bench: register, mode, timer and fault checks
// assumes one 200 MHz clock; timers, idle and restart driven here
`timescale 1ns/1ps
module output_compare_channel_bench;
    import compare_channel_pkg::*;
    logic        ref_clk = 1'b0, nrst = 1'b0, regWr = 1'b0, regRd = 1'b0;
    logic [3:0]  regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0, regRdata;
    logic [15:0] secondTimer = 16'hffff, thirdTimer = 16'hffff;
    logic        periodRestart = 1'b0, cpuIdle = 1'b0, tripReq = 1'b0;
    logic        faultPin, compareOutputPin, compareIrq, ieQ = 1'b0, rdLate = 1'b0;
    logic [7:0]  riseCount, riseBase;
    logic [31:0] expQ[$];
    logic [3:0]  pinTab [6] = '{4'b0000, 4'b0111, 4'b1000, 4'b0110, 4'b0100, 4'b0101};
    logic [2:0]  m;
    int          n_fail = 0, num_checks = 0, irqCount = 0, expIrq = 0, cycles = 0;

    always #2.5 ref_clk = ~ref_clk;

    output_compare_channel uut (.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .secondTimer(secondTimer), .thirdTimer(thirdTimer), .periodRestart(periodRestart),
        .cpuIdle(cpuIdle), .faultPin(faultPin), .compareOutputPin(compareOutputPin),
        .compareIrq(compareIrq));
    compare_load_model load (.ref_clk(ref_clk), .nrst(nrst), .pinLevel(compareOutputPin),
        .tripReq(tripReq), .faultPin(faultPin), .riseCount(riseCount));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results

    // read data stand only in the cycle after the strobe, so look mid-cycle
    always @(posedge ref_clk) rdLate <= regRd;
    always @(negedge ref_clk) begin
        if (rdLate) check(regRdata, expQ.pop_front());
    end
    always @(posedge ref_clk) if (compareIrq === 1'b1) irqCount++;

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            results();
        end
    end

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regAddr <= a; regWdata <= d; regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        regAddr <= a; regRd <= 1'b1;
        expQ.push_back(e);
        @(posedge ref_clk);
        regRd <= 1'b0;
    endtask : rd

    // pin level is visible through the status word next to irq enable
    task automatic pin(input logic p);
        rd(4'hc, {30'h0, p, ieQ});
    endtask : pin

    // filler keeps the top bit set so it never equals a programmed value
    function automatic logic [15:0] fill();
        return 16'h8000 | 16'($urandom);
    endfunction : fill

    task automatic hit(input logic [15:0] s2, input logic [15:0] s3, input logic ev);
        @(posedge ref_clk);
        secondTimer <= s2; thirdTimer <= s3;
        @(posedge ref_clk);
        secondTimer <= fill(); thirdTimer <= fill();
        if (ev && ieQ) expIrq++;
    endtask : hit

    task automatic restart();
        @(posedge ref_clk);
        periodRestart <= 1'b1;
        @(posedge ref_clk);
        periodRestart <= 1'b0;
    endtask : restart

    initial begin
        void'($urandom(32'hdb867498));
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        // reset values, reserved bits, read-only fault bit, unmapped place
        rd(4'h0, 32'h0);
        rd(4'h4, 32'h0);
        pin(1'b0);
        wr(4'h2, 32'hffff_ffff);
        rd(4'h2, 32'h0);
        wr(4'h0, 32'hffff_ffff);
        rd(4'h0, 32'h0000_a02f);
        wr(4'h0, 32'h0);
        wr(4'h4, 32'h5);
        wr(4'h8, 32'h7);
        wr(4'hc, 32'h1);
        ieQ = 1'b1;
        // modes 000 to 101: primary, secondary, primary hit
        for (int i = 0; i < 6; i++) begin
            m = 3'(i);
            wr(4'h0, {16'h0, 1'b1, 12'h0, m});
            pin(pinTab[i][3]);
            hit(16'h5, fill(), m != 3'h0);
            pin(pinTab[i][2]);
            hit(16'h7, fill(), m >= 3'h4);
            pin(pinTab[i][1]);
            hit(16'h5, fill(), m != 3'h0);
            pin(pinTab[i][0]);
            check(irqCount, expIrq);
        end
        // channel off: no pin change, no event
        wr(4'h0, 32'h0000_0001); // next access waits a cycle after disable
        hit(16'h5, fill(), 1'b0);
        pin(1'b0);
        // stop in idle, then keep running in idle
        wr(4'h0, 32'h0000_a001);
        cpuIdle <= 1'b1;
        hit(16'h5, fill(), 1'b0);
        pin(1'b0);
        wr(4'h0, 32'h0000_8001);
        hit(16'h5, fill(), 1'b1);
        pin(1'b1);
        cpuIdle <= 1'b0;
        // third timer selected: second timer ignored
        wr(4'h0, 32'h0000_8009);
        hit(16'h5, fill(), 1'b0);
        pin(1'b0);
        hit(fill(), 16'h5, 1'b1);
        pin(1'b1);
        // wide compare needs the upper half too; narrow uses the low half
        wr(4'h4, 32'h0001_0005);
        wr(4'h0, 32'h0000_8021);
        hit(16'h5, fill(), 1'b0);
        pin(1'b0);
        hit(16'h5, 16'h1, 1'b1);
        pin(1'b1);
        wr(4'h0, 32'h0000_8001);
        hit(16'h5, fill(), 1'b1);
        pin(1'b1);
        check(irqCount, expIrq);
        // pwm: high at restart, low on reloaded primary
        wr(4'h4, 32'h5);
        wr(4'h8, 32'h9);
        wr(4'h0, 32'h0000_8006);
        riseBase = riseCount;
        for (int i = 0; i < 3; i++) begin
            restart();
            pin(1'b1);
            hit(16'h5, fill(), 1'b0);
            hit(16'h9, fill(), 1'b1);
            pin(1'b0);
        end
        check(riseCount - riseBase, 8'h03);
        rd(4'h4, 32'h9);
        // fault ignored in 110, honoured in 111
        tripReq <= 1'b1;
        restart();
        repeat (4) @(posedge ref_clk);
        pin(1'b1);
        rd(4'h0, 32'h0000_8006);
        wr(4'h0, 32'h0000_8007);
        restart();
        repeat (4) @(posedge ref_clk);
        pin(1'b0);
        rd(4'h0, 32'h0000_8017);
        // trip gone: a write with bit 4 clear must not clear the latched flag
        tripReq <= 1'b0;
        repeat (4) @(posedge ref_clk);
        wr(4'h0, 32'h0000_8007);
        rd(4'h0, 32'h0000_8017);
        restart();
        pin(1'b0);
        wr(4'h0, 32'h0000_8006);
        rd(4'h0, 32'h0000_8006);
        // irq enable cleared: match still moves the pin, no request
        wr(4'hc, 32'h0);
        ieQ = 1'b0;
        wr(4'h0, 32'h0000_8001);
        hit(16'h9, fill(), 1'b1);
        pin(1'b1);
        check(irqCount, expIrq);
        repeat (3) @(posedge ref_clk);
        results();
    end
endmodule : output_compare_channel_bench
